/* touch_panel_command_scan_ctrl.v */
// AHB-Lite controlled touch panel scan sequencer with command scan and interval countdown
`timescale 1ns/1ps
`include "touch_panel_command_scan_ctrl_regs.vh"

// How it works
// - Command scan settle wait only when enable bit set
// - Drive field on pins; 11110, 11011 meanings
// - Support X and Y measurement drive patterns
// - Converter command codes, 1111 reserved
// - Command register contents act only in mode 01; a write also restarts a coordinate scan set
// - Command scan drives pins, issues command
// - Power-down ignored for ten-bit converter
// - Reserved upper bits read back zero
// - Live 11-bit countdown readable
// - Power, mode 10, enable: main battery
// - Power, mode 11, enable, auto scan clear: sub battery
// - Mode 11, auto scan flags plus enable: pen wait
// - Mode 00 with scan-start: coordinate scan
// - Mode 00 without scan-start or auto scan: pen wait only
// - Interval counts down from setting in 30 us ticks; sets wait only for its first hit
// - Settle wait ends on the tick after setting ticks of 30 us have been counted (setting plus one ticks)
// - Converter select: 1 ten-bit, 0 twelve-bit
module touch_panel_command_scan_ctrl #(
  parameter TICK_CYCLES = `TICK_CYCLES
)(
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire hready,
  input wire [31:0] hwdata,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire pen_touch,
  output reg [4:0] panel_control_pins,
  output reg [3:0] converter_cmd_out,
  output reg converter_cmd_valid,
  output wire converter_select
);

  localparam [6:0] ST_DISABLE = 7'h01;
  localparam [6:0] ST_STANDBY = 7'h02;
  localparam [6:0] ST_COMMAND = 7'h04;
  localparam [6:0] ST_MAIN_BATT = 7'h08;
  localparam [6:0] ST_SUB_BATT = 7'h10;
  localparam [6:0] ST_PEN_WAIT = 7'h20;
  localparam [6:0] ST_COORD_SCAN = 7'h40;

  // Register bus decode used for both read and write paths
  function [2:0] reg_sel;
    input [31:0] addr;
    begin
      if (addr == `IDX_SAMPLE_INTERVAL << 2)
        reg_sel = 3'h1;
      else if (addr == `IDX_SETTLE_CONFIG << 2)
        reg_sel = 3'h2;
      else if (addr == `IDX_SCAN_COMMAND << 2)
        reg_sel = 3'h3;
      else if (addr == `IDX_INTERVAL_COUNTDOWN << 2)
        reg_sel = 3'h4;
      else if (addr == `IDX_UNIT_CONTROL << 2)
        reg_sel = 3'h5;
      else
        reg_sel = 3'h0;
    end
  endfunction

  // Drive pattern of each coordinate scan phase; no-voltage phases keep the panel from shorting
  function [4:0] phase_drive;
    input [3:0] ph;
    begin
      case (ph)
        4'h0: phase_drive = `DRIVE_PEN_DETECT;
        4'h2: phase_drive = `DRIVE_Y_HIGH;
        4'h4: phase_drive = `DRIVE_Y_LOW;
        4'h6: phase_drive = `DRIVE_X_HIGH;
        4'h8: phase_drive = `DRIVE_X_LOW;
        default: phase_drive = `DRIVE_NO_VOLTAGE;
      endcase
    end
  endfunction

  function [3:0] phase_conv;
    input [3:0] ph;
    begin
      case (ph)
        4'h0: phase_conv = `CONV_PEN_DETECT;
        4'h2: phase_conv = `CONV_MEASURE_X;
        4'h4: phase_conv = `CONV_MEASURE_X;
        4'h6: phase_conv = `CONV_MEASURE_Y;
        4'h8: phase_conv = `CONV_MEASURE_Y;
        default: phase_conv = `CONV_POWER_DOWN;
      endcase
    end
  endfunction

  reg [10:0] sample_interval_q;
  reg [8:0] settle_config_q;
  reg [9:0] scan_command_q;
  reg [7:0] unit_control_q;
  reg contact_change_q;
  reg [10:0] live_count_q;
  reg interval_hit_q;
  reg [6:0] state_q;
  reg [6:0] state_d;
  reg [15:0] prescale_q;
  reg [3:0] settle_cnt_q;
  reg settle_busy_q;
  reg [3:0] phase_q;
  reg set_done_q;
  reg pen_prev_q;
  reg wr_pend_q;
  reg rd_pend_q;
  reg [2:0] sel_q;
  reg [15:0] rd_mux;

  wire [1:0] unit_mode_field = unit_control_q[`CTL_MODE_HI:`CTL_MODE_LO];
  wire unit_power_on = unit_control_q[`CTL_POWER];
  wire sequencer_enable = unit_control_q[`CTL_SEQ_EN];
  wire scan_type_select = unit_control_q[`CTL_SCAN_TYPE];
  wire auto_scan_enable = unit_control_q[`CTL_AUTO_SCAN];
  wire auto_stop_enable = unit_control_q[`CTL_AUTO_STOP];
  wire scan_start_bit = unit_control_q[`CTL_SCAN_START];
  wire [3:0] settle_wait_time = settle_config_q[`CFG_SETTLE_HI:`CFG_SETTLE_LO];
  wire settle_wait_enable = scan_command_q[`CMD_SETTLE_ON];
  wire [4:0] panel_drive_field = scan_command_q[`CMD_DRIVE_HI:`CMD_DRIVE_LO];
  wire [3:0] converter_command = scan_command_q[`CMD_CONV_HI:`CMD_CONV_LO];
  assign converter_select = settle_config_q[`CFG_CONV_SELECT];

  wire addr_phase = hsel & hready & htrans[1];
  wire tick = (prescale_q == TICK_CYCLES[15:0] - 16'h0001);
  wire active = ~(state_q[0] | state_q[1]);
  wire wr_cmd = wr_pend_q & (sel_q == 3'h3);
  wire wr_ctl = wr_pend_q & (sel_q == 3'h5);
  // A wait state on reads lets a write in the previous cycle show up in the answer
  assign hreadyout = ~rd_pend_q;
  assign hresp = 1'b0;

  always @*
  begin
    rd_mux = 16'h0000;
    if (sel_q == 3'h1)
      rd_mux = {5'h00, sample_interval_q};
    else if (sel_q == 3'h2)
      rd_mux = {7'h00, settle_config_q};
    else if (sel_q == 3'h3)
      rd_mux = {6'h00, scan_command_q};
    else if (sel_q == 3'h4)
      rd_mux = {5'h00, live_count_q};
    else if (sel_q == 3'h5)
      rd_mux = {state_q, contact_change_q, unit_control_q};
  end

  always @*
  begin
    state_d = state_q;
    if (!unit_power_on)
      state_d = ST_DISABLE;
    else
    begin
      case (state_q)
        ST_DISABLE: state_d = ST_STANDBY;
        ST_STANDBY:
        begin
          if (sequencer_enable)
          begin
            if (unit_mode_field == `MODE_COMMAND)
              state_d = ST_COMMAND;
            else if (unit_mode_field == `MODE_MAIN_BATT)
              state_d = ST_MAIN_BATT;
            else if (unit_mode_field == `MODE_SUB_BATT && auto_scan_enable)
              state_d = ST_PEN_WAIT;
            else if (unit_mode_field == `MODE_SUB_BATT)
              state_d = ST_SUB_BATT;
            else if (scan_start_bit)
              state_d = ST_COORD_SCAN;
            else
              state_d = ST_PEN_WAIT;
          end
        end
        ST_PEN_WAIT:
        begin
          if (!sequencer_enable)
            state_d = ST_STANDBY;
          else if (pen_touch && (auto_scan_enable || scan_start_bit))
            state_d = ST_COORD_SCAN;
        end
        ST_COORD_SCAN:
        begin
          if (!sequencer_enable)
            state_d = ST_STANDBY;
          else if (auto_stop_enable && !pen_touch && set_done_q)
            state_d = ST_PEN_WAIT;
        end
        default:
        begin
          if (!sequencer_enable)
            state_d = ST_STANDBY;
        end
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      sel_q <= 3'h0;
      hrdata <= 32'h00000000;
      sample_interval_q <= `RST_SAMPLE_INTERVAL;
      settle_config_q <= `RST_SETTLE_CONFIG;
      scan_command_q <= `RST_SCAN_COMMAND;
      unit_control_q <= 8'h00;
      contact_change_q <= 1'b0;
      pen_prev_q <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_pend_q <= addr_phase & hwrite;
      rd_pend_q <= addr_phase & ~hwrite;
      if (addr_phase)
        sel_q <= reg_sel(haddr);
      if (rd_pend_q)
        hrdata <= {16'h0000, rd_mux};
      // Only defined fields are stored; countdown and reserved bits drop the write
      if (wr_pend_q && sel_q == 3'h1)
        sample_interval_q <= hwdata[10:0];
      if (wr_pend_q && sel_q == 3'h2)
        settle_config_q <= hwdata[8:0];
      if (wr_cmd)
        scan_command_q <= hwdata[9:0];
      if (wr_ctl)
        unit_control_q <= hwdata[7:0];
      pen_prev_q <= pen_touch;
      // A contact change in the clearing cycle keeps the flag set
      if (pen_touch != pen_prev_q)
        contact_change_q <= 1'b1;
      else if (wr_ctl && hwdata[`CTL_CONTACT_CHG])
        contact_change_q <= 1'b0;
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_DISABLE;
      prescale_q <= 16'h0000;
      live_count_q <= `RST_SAMPLE_INTERVAL;
      interval_hit_q <= 1'b0;
    end
    else if (clk_en)
    begin
      state_q <= state_d;
      if (!active || tick)
        prescale_q <= 16'h0000;
      else
        prescale_q <= prescale_q + 16'h0001;
      if (!active)
        interval_hit_q <= 1'b0;
      else if (tick && live_count_q == 11'h000)
      begin
        live_count_q <= sample_interval_q;
        interval_hit_q <= 1'b1;
      end
      else if (tick)
        live_count_q <= live_count_q - 11'h001;
      else if (state_q[6] && phase_q == 4'h0 && !settle_busy_q && set_done_q)
        interval_hit_q <= 1'b0;
    end
  end

  // Settle counter counts ticks of 30 us; it also paces each coordinate phase
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      settle_cnt_q <= 4'h0;
      settle_busy_q <= 1'b0;
      phase_q <= 4'h0;
      set_done_q <= 1'b0;
      panel_control_pins <= `DRIVE_NO_VOLTAGE;
      converter_cmd_out <= `CONV_POWER_DOWN;
      converter_cmd_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      converter_cmd_valid <= 1'b0;
      if (state_d != state_q || wr_cmd)
      begin
        settle_busy_q <= 1'b1;
        settle_cnt_q <= 4'h0;
        phase_q <= scan_type_select ? 4'h0 : 4'h1;
        set_done_q <= 1'b0;
      end
      else if (state_q[2])
      begin
        panel_control_pins <= panel_drive_field;
        if (settle_busy_q && (!settle_wait_enable || (tick && settle_cnt_q >= settle_wait_time)))
        begin
          settle_busy_q <= 1'b0;
          if (!(converter_select && converter_command == `CONV_POWER_DOWN))
          begin
            converter_cmd_out <= converter_command;
            converter_cmd_valid <= 1'b1;
          end
        end
        else if (settle_busy_q && tick)
          settle_cnt_q <= settle_cnt_q + 4'h1;
      end
      else if (state_q[6])
      begin
        panel_control_pins <= phase_drive(phase_q);
        converter_cmd_out <= phase_conv(phase_q);
        if (set_done_q)
        begin
          // Next set waits for the first interval hit; the hit flag then stays set, so later sets start at once
          if (interval_hit_q)
          begin
            set_done_q <= 1'b0;
            phase_q <= scan_type_select ? 4'h0 : 4'h1;
            settle_busy_q <= 1'b1;
          end
        end
        else if (tick && settle_cnt_q >= settle_wait_time)
        begin
          settle_cnt_q <= 4'h0;
          converter_cmd_valid <= !(converter_select && phase_conv(phase_q) == `CONV_POWER_DOWN);
          if (phase_q == `SCAN_LAST_PHASE)
            set_done_q <= 1'b1;
          else
            phase_q <= phase_q + 4'h1;
        end
        else if (tick)
          settle_cnt_q <= settle_cnt_q + 4'h1;
      end
      else
      begin
        settle_busy_q <= 1'b0;
        if (state_q[5])
        begin
          panel_control_pins <= `DRIVE_PEN_DETECT;
          converter_cmd_out <= `CONV_PEN_DETECT;
        end
        else
        begin
          panel_control_pins <= `DRIVE_NO_VOLTAGE;
          if (state_q[3])
            converter_cmd_out <= `CONV_MAIN_BATT;
          else if (state_q[4])
            converter_cmd_out <= `CONV_SUB_BATT;
          else
            converter_cmd_out <= `CONV_POWER_DOWN;
        end
      end
    end
  end

endmodule

/* touch_panel_command_scan_ctrl_regs.vh */
// Register indices, field positions, reset values and timing counts of the touch panel scan control
`ifndef TOUCH_PANEL_COMMAND_SCAN_CTRL_REGS_VH
`define TOUCH_PANEL_COMMAND_SCAN_CTRL_REGS_VH
`define IDX_SAMPLE_INTERVAL 32'h0b000126
`define IDX_SETTLE_CONFIG 32'h0b000128
`define IDX_SCAN_COMMAND 32'h0b00012a
`define IDX_INTERVAL_COUNTDOWN 32'h0b00013c
`define IDX_UNIT_CONTROL 32'h0b000140
`define RST_SAMPLE_INTERVAL 11'h0a7
`define RST_SETTLE_CONFIG 9'h077
`define RST_SCAN_COMMAND 10'h1be
`define CMD_SETTLE_ON 9
`define CMD_DRIVE_HI 8
`define CMD_DRIVE_LO 4
`define CMD_CONV_HI 3
`define CMD_CONV_LO 0
`define CFG_CONV_SELECT 8
`define CFG_SETTLE_HI 3
`define CFG_SETTLE_LO 0
`define CTL_POWER 0
`define CTL_MODE_HI 2
`define CTL_MODE_LO 1
`define CTL_SEQ_EN 3
`define CTL_SCAN_TYPE 4
`define CTL_AUTO_SCAN 5
`define CTL_AUTO_STOP 6
`define CTL_SCAN_START 7
`define CTL_CONTACT_CHG 8
`define CTL_STATE_LO 9
`define MODE_MANUAL 2'h0
`define MODE_COMMAND 2'h1
`define MODE_MAIN_BATT 2'h2
`define MODE_SUB_BATT 2'h3
`define DRIVE_PEN_DETECT 5'h1e
`define DRIVE_NO_VOLTAGE 5'h1b
`define DRIVE_X_HIGH 5'h1a
`define DRIVE_Y_HIGH 5'h19
`define DRIVE_X_LOW 5'h13
`define DRIVE_Y_LOW 5'h0b
`define CONV_POWER_DOWN 4'he
`define CONV_PEN_DETECT 4'h3
`define CONV_MAIN_BATT 4'h0
`define CONV_SUB_BATT 4'h2
`define CONV_MEASURE_X 4'h1
`define CONV_MEASURE_Y 4'h3
`define TICK_NS 30000
`define CLK_PERIOD_NS 50
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define SCAN_LAST_PHASE 4'h9
`endif

/* touch_panel_command_scan_ctrl_unused.v */
// No logic here; the whole block sits in the main design file

/* touch_panel_command_scan_ctrl_props.sv */
// Port checks for the touch panel scan control
`timescale 1ns/1ps
module touch_panel_command_scan_ctrl_props (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire [4:0] panel_control_pins,
  input wire [3:0] converter_cmd_out,
  input wire converter_cmd_valid,
  input wire converter_select
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence take_s;
    clk_en && hsel && hready && htrans[1];
  endsequence
  sequence one_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_wait: assert property (take_s ##0 !hwrite |=> one_wait) else $error("read wait wrong");
  a_write_nowait: assert property (take_s ##0 hwrite |=> hreadyout) else $error("write stalled");
  a_wait_once: assert property (!hreadyout && clk_en |=> hreadyout) else $error("wait too long");
  a_upper_zero: assert property (hreadyout |-> hrdata[31:16] == 16'h0) else $error("upper bits set");
  a_resp_okay: assert property (hresp == 1'b0) else $error("error response");
  a_pd_ignored: assert property (converter_cmd_valid && converter_select |-> converter_cmd_out != 4'he)
    else $error("power-down issued");
  a_pins_legal: assert property (panel_control_pins inside {5'h1e, 5'h1b, 5'h1a, 5'h19, 5'h13, 5'h0b})
    else $error("illegal drive");
  a_select_by_write: assert property ($changed(converter_select) |->
    $past(clk_en && hsel && hready && htrans[1] && hwrite, 2)) else $error("select moved alone");
endmodule
bind touch_panel_command_scan_ctrl touch_panel_command_scan_ctrl_props chk (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .panel_control_pins(panel_control_pins), .converter_cmd_out(converter_cmd_out),
  .converter_cmd_valid(converter_cmd_valid), .converter_select(converter_select));

/* panel_adc_converter_select.sv */
// Behavioural panel and serial converter on the far side
`timescale 1ns/1ps
module panel_adc_converter_select (
  input wire hclk,
  input wire touched,
  input wire [4:0] panel_control_pins,
  input wire [3:0] converter_cmd_out,
  input wire converter_cmd_valid,
  output reg pen_touch,
  output reg [7:0] cmd_count
);
  initial
  begin
    pen_touch = 1'b0;
    cmd_count = 8'h00;
  end
  // Contact only shows while the panel is biased for detection
  always @(posedge hclk)
    pen_touch <= touched && panel_control_pins == 5'h1e;
  // Counts commands so the bench can see a dropped one
  always @(posedge hclk)
    if (converter_cmd_valid)
      cmd_count <= cmd_count + 8'h01;
endmodule

/* test_touch_panel_command_scan_ctrl.sv */
// Self-checking bench for the touch panel scan control
`timescale 1ns/1ps
`include "touch_panel_command_scan_ctrl_regs.vh"
module test_touch_panel_command_scan_ctrl;
  localparam TICK = 4;
  localparam [31:0] A_SIV = `IDX_SAMPLE_INTERVAL * 4;
  localparam [31:0] A_STB = `IDX_SETTLE_CONFIG * 4;
  localparam [31:0] A_CMD = `IDX_SCAN_COMMAND * 4;
  localparam [31:0] A_CIV = `IDX_INTERVAL_COUNTDOWN * 4;
  localparam [31:0] A_CTL = `IDX_UNIT_CONTROL * 4;
  localparam [159:0] CTL = {32'h1, 32'h81, 32'h67, 32'h7, 32'h5};
  localparam [159:0] ST = {32'h4000, 32'h8000, 32'h4000, 32'h2000, 32'h1000};
  localparam [159:0] PN = {32'h1e, 32'h0, 32'h1e, 32'h1b, 32'h1b};
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg clk_en = 1'b1;
  reg hsel = 1'b1;
  reg [31:0] haddr = 32'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [2:0] hsize = 3'h2;
  reg [31:0] hwdata = 32'h0;
  reg touched = 1'b0;
  reg [31:0] rd;
  reg [31:0] v;
  wire hreadyout, hresp, cmd_valid, conv_sel, pen_touch;
  wire [31:0] hrdata;
  wire [4:0] pins;
  wire [3:0] cmd;
  wire [7:0] cmd_count;
  integer mismatches = 0;
  integer compares = 0;
  integer i;
  integer n;
  touch_panel_command_scan_ctrl #(.TICK_CYCLES(TICK)) DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pen_touch(pen_touch),
    .panel_control_pins(pins), .converter_cmd_out(cmd), .converter_cmd_valid(cmd_valid),
    .converter_select(conv_sel));
  panel_adc_converter_select far (.hclk(hclk), .touched(touched), .panel_control_pins(pins), .converter_cmd_out(cmd),
    .converter_cmd_valid(cmd_valid), .pen_touch(pen_touch), .cmd_count(cmd_count));
  initial
    forever #25 hclk = ~hclk;
  task stop_test;
    begin
      if (mismatches == 0 && compares > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task check(input [31:0] e, input [31:0] g, input string what);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        $display("unexpected %0s expected %h seen %h", what, e, g);
        mismatches = mismatches + 1;
      end
    end
  endtask
  // Bounded wait for a rising edge where sig is high
  task wait_hi(input integer lim, input bit cmdw);
    begin
      n = 0;
      @(posedge hclk);
      while ((cmdw ? cmd_valid : hreadyout) !== 1'b1 && n < lim)
      begin
        n = n + 1;
        @(posedge hclk);
      end
      if ((cmdw ? cmd_valid : hreadyout) !== 1'b1)
      begin
        mismatches = mismatches + 1;
        stop_test;
      end
    end
  endtask
  task bus(input [31:0] a, input w, input [31:0] wd);
    begin
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_hi(50, 0);
      htrans <= 2'h0;
      hwdata <= wd;
      wait_hi(50, 0);
      rd = hrdata;
    end
  endtask
  task rchk(input [31:0] a, input [31:0] m, input [31:0] e, input string what);
    begin
      bus(a, 1'b0, 32'h0);
      check(e, rd & m, what);
    end
  endtask
  task t_reset;
    begin
      rchk(A_SIV, 32'hffffffff, 32'h0a7, "interval");
      rchk(A_STB, 32'hffffffff, 32'h077, "settle");
      rchk(A_CMD, 32'hffffffff, 32'h1be, "command");
      rchk(A_CIV, 32'hffffffff, 32'h0a7, "countdown");
      rchk(A_CTL, 32'hffffffff, 32'h200, "control");
      rchk(32'h2c000600, 32'hffffffff, 32'h0, "unmapped");
    end
  endtask
  task t_readonly;
    begin
      bus(A_CIV, 1'b1, 32'h000007ff);
      rchk(A_CIV, 32'hffffffff, 32'h0a7, "countdown");
      bus(A_CMD, 1'b1, 32'h000003ad);
      rchk(A_CMD, 32'hffffffff, 32'h3ad, "command");
    end
  endtask
  // Only listed drive patterns are written
  task t_command;
    begin
      bus(A_SIV, 1'b1, 32'h5);
      bus(A_STB, 1'b1, 32'h102);
      @(posedge hclk);
      check(1, conv_sel, "select");
      bus(A_CMD, 1'b1, 32'h19a);
      bus(A_CTL, 1'b1, 32'h1);
      rchk(A_CTL, 32'hfe00, 32'h400, "standby");
      bus(A_CTL, 1'b1, 32'hb);
      wait_hi(20, 1);
      check(32'ha, cmd, "command");
      repeat (2) @(posedge hclk);
      check(32'h19, pins, "pins");
      v = cmd_count;
      bus(A_CMD, 1'b1, 32'h1be);
      repeat (20) @(posedge hclk);
      check(v, cmd_count, "pulses");
      bus(A_CMD, 1'b1, 32'h3ad);
      wait_hi(60, 1);
      check(1, n >= 2 * TICK, "settle");
      check(32'hd, cmd, "command");
      check(32'h1a, pins, "pins");
      bus(A_CMD, 1'b1, 32'h1ad);
      wait_hi(20, 1);
      check(1, n <= 3, "no settle");
      bus(A_STB, 1'b1, 32'h2);
      @(posedge hclk);
      check(0, conv_sel, "select");
      bus(A_CMD, 1'b1, 32'h1be);
      wait_hi(20, 1);
      check(32'he, cmd, "command");
      // Countdown starts from its reset value, so its first reload comes late
      repeat (700) @(posedge hclk);
      bus(A_CIV, 1'b0, 32'h0);
      v = rd;
      check(1, v <= 5, "countdown");
      repeat (TICK) @(posedge hclk);
      bus(A_CIV, 1'b0, 32'h0);
      check(1, rd !== v && rd <= 5, "countdown");
    end
  endtask
  task t_modes;
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        bus(A_CTL, 1'b1, 32'h1);
        bus(A_CTL, 1'b1, CTL[i*32 +: 32]);
        bus(A_CTL, 1'b1, CTL[i*32 +: 32] | 32'h8);
        repeat (3) @(posedge hclk);
        rchk(A_CTL, 32'hfe00, ST[i*32 +: 32], "state");
        if (i != 3)
          check(PN[i*32 +: 32], pins, "pins");
      end
      touched <= 1'b1;
      repeat (3 * TICK) @(posedge hclk);
      rchk(A_CTL, 32'hfe00, 32'h4000, "suspend");
      touched <= 1'b0;
    end
  endtask
  initial
  begin
    // DMA, interrupt and clock masks live outside this block
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_readonly;
    t_command;
    t_modes;
    stop_test;
  end
endmodule
